// *** verilog/ueb_pkg.sv ***
// Constants for the endpoint buffer command decoder
package ueb_pkg;
    localparam int NUM_EP = 6;
    localparam int NUM_BUF = 7;
    localparam int BUF_BYTES = 130;
    localparam int PTR_W = 8;
    localparam int ADDR_W = 10;
    localparam logic [PTR_W-1:0] LEN_POS = 8'h01;
    localparam logic [PTR_W-1:0] PAYLOAD_POS = 8'h02;
    localparam logic [2:0] MAIN_IN_EP = 3'h5;
    localparam logic [2:0] MAIN_IN_BANK2 = 3'h6;
    localparam logic [7:0] CMD_SEL_LAST = 8'h05;
    localparam logic [7:0] CMD_STALL_FIRST = 8'h40;
    localparam logic [7:0] CMD_STALL_LAST = 8'h45;
    localparam logic [7:0] CMD_BUFFER = 8'hf0;
    localparam logic [7:0] CMD_ACK_SETUP = 8'hf1;
    localparam logic [7:0] CMD_CLEAR = 8'hf2;
    localparam logic [7:0] CMD_FRAME = 8'hf5;
    localparam logic [7:0] CMD_RESUME = 8'hf6;
    localparam logic [7:0] CMD_VALIDATE = 8'hfa;
    localparam int CLK_HZ = 20_000_000;
    localparam int RESUME_MS = 10;
    localparam int RESUME_CYC = CLK_HZ / 1000 * RESUME_MS;
    localparam int RES_W = 18;
    typedef enum logic [2:0] {
        UEB_IDLE = 3'h0,
        UEB_SELECT = 3'h1,
        UEB_BUFFER = 3'h3,
        UEB_STALL = 3'h2,
        UEB_FRAME = 3'h6
    } ueb_mode_t;
endpackage

// *** verilog/ueb_cmd_decoder.sv ***
// Endpoint buffer command decoder with DMA fill path
//
// Functional notes
// - F0h opens buffer access; each data write stores one byte, up to 130.
// - DMA writes skip reserved and length bytes, starting at payload one.
// - DMA buffer is sent and switched when completely filled or at end-of-transfer.
// - End-of-transfer in a cycle without a DMA write sends the current buffer, full or not.
// - DMA on main endpoint switches to the second buffer at the boundary.
// - A received packet sets full; later packets get NAK until freed.
// - F2h clears the selected buffer full flag.
// - FAh sets the selected IN buffer full flag for the next IN token.
// - 40-45h plus a byte sets stall; writing zero always reinitialises.
// - A SETUP token unstalls a stalled control endpoint.
// - Leaving stall flushes the buffer and restarts the DATA0 toggle.
// - SETUP flushes the IN buffer and locks validate and clear.
// - F1h releases the lock; it is needed on both control endpoints.
// - F6h drives upstream resume for 10 ms.
// - F5h then one or two reads return the last SOF frame, low first.
// - Codes 00-05h select a buffer and reset the pointer to its start.
// - Each data byte moved advances the buffer pointer by one.
// - Byte one holds the payload count; payload starts at byte two.
`timescale 1ns/10ps
`default_nettype none
module ueb_cmd_decoder #(
    parameter int BUF_BYTES = ueb_pkg::BUF_BYTES,
    parameter int RESUME_CYC = ueb_pkg::RESUME_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cmd_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] din,
    output logic [7:0] dout_q,
    input wire logic dma_wr,
    input wire logic [7:0] dma_din,
    input wire logic transfer_end_n,
    input wire logic [ueb_pkg::NUM_BUF-1:0] sie_rx_done,
    input wire logic [ueb_pkg::NUM_BUF-1:0] sie_tx_done,
    input wire logic sie_setup,
    input wire logic sie_sof,
    input wire logic [10:0] sie_frame,
    output logic [ueb_pkg::NUM_BUF-1:0] full_q,
    output logic [ueb_pkg::NUM_EP-1:0] stall_q,
    output logic [ueb_pkg::NUM_EP-1:0] pid_reset_q,
    output logic [1:0] lock_q,
    output logic resume_q
);
    localparam int NB = ueb_pkg::NUM_BUF;
    localparam int NE = ueb_pkg::NUM_EP;
    localparam int AW = ueb_pkg::ADDR_W;
    localparam int PW = ueb_pkg::PTR_W;
    localparam int RW = ueb_pkg::RES_W;

    logic [7:0] mem [0:NB*BUF_BYTES-1];
    ueb_pkg::ueb_mode_t mode_q;
    logic [2:0] sel_q;
    logic [2:0] st_ep_q;
    logic [PW-1:0] ptr_q;
    logic frame_hi_q;
    logic [10:0] frame_q;
    logic [PW-1:0] dma_ptr_q;
    logic dma_bank_q;
    logic te_s1_q, te_s2_q, te_s3_q;
    logic [RW-1:0] res_cnt_q;
    logic [RW-1:0] res_hold_q;
    logic [NE-1:0] init_d;
    logic [NB-1:0] set_d, clr_d;
    logic [2:0] dma_buf;
    logic eot_evt, dma_last, dma_done, sel_locked;
    logic stall_wr, buf_wr, buf_rd;

    function automatic logic [AW-1:0] baddr(input logic [2:0] b,
                                            input logic [PW-1:0] p);
        baddr = AW'(int'(b) * BUF_BYTES + int'(p));
    endfunction

    // Two flops before the pin is looked at
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            te_s1_q <= 1'b1;
            te_s2_q <= 1'b1;
            te_s3_q <= 1'b1;
        end
        else
        begin
            te_s1_q <= transfer_end_n;
            te_s2_q <= te_s1_q;
            te_s3_q <= te_s2_q;
        end
    end

    always_comb
    begin
        eot_evt = te_s3_q & ~te_s2_q;
        dma_buf = dma_bank_q ? ueb_pkg::MAIN_IN_BANK2 : ueb_pkg::MAIN_IN_EP;
        dma_last = dma_wr && (dma_ptr_q == PW'(BUF_BYTES - 1));
        dma_done = dma_last || (eot_evt && !dma_wr);
        sel_locked = (sel_q < 3'h2) && lock_q[sel_q[0]];
        stall_wr = data_wr && (mode_q == ueb_pkg::UEB_STALL);
        buf_wr = data_wr && (mode_q == ueb_pkg::UEB_BUFFER)
            && (ptr_q < PW'(BUF_BYTES));
        buf_rd = data_rd && (mode_q == ueb_pkg::UEB_BUFFER);
        init_d = '0;
        for (int i = 0; i < NE; i++)
        begin
            if (stall_wr && st_ep_q == 3'(i) && !din[0])
                init_d[i] = 1'b1;
            if (sie_setup && i < 2 && stall_q[i])
                init_d[i] = 1'b1;
        end
        set_d = sie_rx_done;
        clr_d = sie_tx_done;
        for (int i = 0; i < NB; i++)
        begin
            if (cmd_wr && din == ueb_pkg::CMD_VALIDATE && !sel_locked
                && sel_q == 3'(i))
                set_d[i] = 1'b1;
            if (cmd_wr && din == ueb_pkg::CMD_CLEAR && !sel_locked
                && sel_q == 3'(i))
                clr_d[i] = 1'b1;
            if (dma_done && dma_buf == 3'(i))
                set_d[i] = 1'b1;
            if (i < NE && init_d[i])
                clr_d[i] = 1'b1;
        end
        if (init_d[ueb_pkg::MAIN_IN_EP])
            clr_d[ueb_pkg::MAIN_IN_BANK2] = 1'b1;
        if (sie_setup)
            clr_d[1] = 1'b1;
    end

    // Command decode; a new command may cut into any data phase
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= ueb_pkg::UEB_IDLE;
            sel_q <= 3'h0;
            st_ep_q <= 3'h0;
            frame_hi_q <= 1'b0;
        end
        else if (cmd_wr)
        begin
            frame_hi_q <= 1'b0;
            if (din <= ueb_pkg::CMD_SEL_LAST)
            begin
                mode_q <= ueb_pkg::UEB_SELECT;
                sel_q <= din[2:0];
            end
            else if (din >= ueb_pkg::CMD_STALL_FIRST
                     && din <= ueb_pkg::CMD_STALL_LAST)
            begin
                mode_q <= ueb_pkg::UEB_STALL;
                st_ep_q <= din[2:0];
            end
            else if (din == ueb_pkg::CMD_BUFFER)
                mode_q <= ueb_pkg::UEB_BUFFER;
            else if (din == ueb_pkg::CMD_FRAME)
                mode_q <= ueb_pkg::UEB_FRAME;
            else
                mode_q <= ueb_pkg::UEB_IDLE;
        end
        else if (data_rd && mode_q == ueb_pkg::UEB_FRAME)
            frame_hi_q <= 1'b1;
    end

    // Pointer is kept across other commands, reset only by select
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ptr_q <= '0;
        else if (cmd_wr && din <= ueb_pkg::CMD_SEL_LAST)
            ptr_q <= '0;
        else if (buf_wr || buf_rd)
            ptr_q <= ptr_q + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (buf_wr)
            mem[baddr(sel_q, ptr_q)] <= din;
        if (dma_wr)
            mem[baddr(dma_buf, dma_ptr_q)] <= dma_din;
        if (dma_done)
            mem[baddr(dma_buf, ueb_pkg::LEN_POS)] <=
                8'(dma_ptr_q + PW'(dma_wr) - ueb_pkg::PAYLOAD_POS);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            dout_q <= 8'h00;
        else if (data_rd)
        begin
            unique case (mode_q)
                ueb_pkg::UEB_SELECT:
                    dout_q <= {6'h00, stall_q[sel_q], full_q[sel_q]};
                ueb_pkg::UEB_BUFFER:
                    dout_q <= mem[baddr(sel_q, ptr_q)];
                ueb_pkg::UEB_FRAME:
                    dout_q <= frame_hi_q ? {5'h00, frame_q[10:8]}
                        : frame_q[7:0];
                default:
                    dout_q <= 8'h00;
            endcase
        end
    end

    // No overrun guard: a still-full bank is simply overwritten
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dma_ptr_q <= ueb_pkg::PAYLOAD_POS;
            dma_bank_q <= 1'b0;
        end
        else if (dma_done)
        begin
            dma_ptr_q <= ueb_pkg::PAYLOAD_POS;
            dma_bank_q <= ~dma_bank_q;
        end
        else if (dma_wr)
            dma_ptr_q <= dma_ptr_q + 1'b1;
    end

    // Set wins over clear
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            full_q <= '0;
        else
            full_q <= set_d | (full_q & ~clr_d);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stall_q <= '0;
            pid_reset_q <= '0;
        end
        else
        begin
            pid_reset_q <= init_d;
            if (sie_setup)
                stall_q[1:0] <= 2'b00;
            if (stall_wr)
                stall_q[st_ep_q] <= din[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            lock_q <= 2'b00;
        else if (sie_setup)
            lock_q <= 2'b11;
        else if (cmd_wr && din == ueb_pkg::CMD_ACK_SETUP && sel_q < 3'h2)
            lock_q[sel_q[0]] <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            frame_q <= 11'h000;
        else if (sie_sof)
            frame_q <= sie_frame;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            resume_q <= 1'b0;
            res_cnt_q <= '0;
        end
        else if (cmd_wr && din == ueb_pkg::CMD_RESUME)
        begin
            resume_q <= 1'b1;
            res_cnt_q <= RW'(RESUME_CYC - 1);
        end
        else if (resume_q)
        begin
            if (res_cnt_q == '0)
                resume_q <= 1'b0;
            else
                res_cnt_q <= res_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            res_hold_q <= '0;
        else
            res_hold_q <= resume_q ? res_hold_q + 1'b1 : '0;
    end

    a_resume_len: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(resume_q) |-> res_hold_q == RW'(RESUME_CYC))
        else $error("resume length wrong");
    a_resume_start: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_wr && din == ueb_pkg::CMD_RESUME |=> resume_q)
        else $error("resume not started");
    a_setup_lock: assert property (@(posedge core_clk) disable iff (!rst_b)
        sie_setup && !stall_wr |=> lock_q == 2'b11 && stall_q[1:0] == 2'b00)
        else $error("setup did not lock");
    a_locked_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_wr && din == ueb_pkg::CMD_CLEAR && sel_locked && full_q[sel_q]
        && !sie_tx_done[sel_q] && !sie_setup |=> full_q[$past(sel_q)])
        else $error("clear acted while locked");
    a_clear_frees: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_wr && din == ueb_pkg::CMD_CLEAR && !sel_locked
        && !set_d[sel_q] |=> !full_q[$past(sel_q)])
        else $error("clear did not free buffer");
    a_validate_sets: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_wr && din == ueb_pkg::CMD_VALIDATE && !sel_locked
        |=> full_q[$past(sel_q)])
        else $error("validate did not set full");
    a_zero_inits: assert property (@(posedge core_clk) disable iff (!rst_b)
        stall_wr && !din[0] |=> pid_reset_q[$past(st_ep_q)]
        && !stall_q[$past(st_ep_q)])
        else $error("zero stall write did not reinit");
    a_ptr_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        (buf_wr || buf_rd) && !cmd_wr |=> ptr_q == $past(ptr_q) + 1'b1)
        else $error("pointer did not advance");
    a_dma_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
        dma_done |=> dma_ptr_q == ueb_pkg::PAYLOAD_POS
        && dma_bank_q != $past(dma_bank_q) && full_q[$past(dma_buf)])
        else $error("dma buffer switch wrong");
endmodule
`default_nettype wire

// *** tb/ueb_micro_model.sv ***
// Microcontroller and DMA side model driving the command port
`timescale 1ns/10ps
`default_nettype none
module ueb_micro_model (
    input wire logic core_clk,
    output logic cmd_wr,
    output logic data_wr,
    output logic data_rd,
    output logic [7:0] din,
    input wire logic [7:0] dout_q,
    output logic dma_wr,
    output logic [7:0] dma_din,
    output logic transfer_end_n
);
    initial
    begin
        cmd_wr = 1'b0;
        data_wr = 1'b0;
        data_rd = 1'b0;
        din = 8'h00;
        dma_wr = 1'b0;
        dma_din = 8'h00;
        transfer_end_n = 1'b1;
    end
    // Waits one falling edge first, so back-to-back calls leave a gap
    task automatic strobe(input logic c, input logic [7:0] b);
        @(negedge core_clk);
        din = b;
        cmd_wr = c;
        data_wr = !c;
        @(negedge core_clk);
        cmd_wr = 1'b0;
        data_wr = 1'b0;
        din = ~b; // Released bus never shows the stale byte
    endtask
    task automatic rd(output logic [7:0] v);
        @(negedge core_clk);
        data_rd = 1'b1;
        @(negedge core_clk);
        data_rd = 1'b0;
        v = dout_q;
    endtask
    task automatic load(input logic [2:0] ep, input logic [7:0] len,
                        input logic [7:0] p [0:7]);
        strobe(1'b1, {5'h00, ep});
        strobe(1'b1, ueb_pkg::CMD_BUFFER);
        strobe(1'b0, 8'h00);
        strobe(1'b0, len);
        for (int i = 0; i < len; i++)
        begin
            strobe(1'b0, p[i]); // Stops at the length, never past it
        end
    endtask
    task automatic dma_burst(input int n, input logic [7:0] first);
        @(negedge core_clk);
        dma_wr = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            dma_din = first + 8'(i);
            @(negedge core_clk);
        end
        dma_wr = 1'b0;
        dma_din = ~dma_din;
    endtask
    task automatic eot();
        @(negedge core_clk);
        transfer_end_n = 1'b0;
        repeat (2) @(negedge core_clk);
        transfer_end_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** tb/ueb_cmd_decoder_bench.sv ***
// Self-checking bench for the endpoint buffer command decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
err_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module ueb_cmd_decoder_bench;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_wr, data_wr, data_rd, dma_wr, transfer_end_n;
    logic [7:0] din, dout_q, dma_din, v, f0, len;
    logic [6:0] sie_rx_done = 7'h00;
    logic [6:0] sie_tx_done = 7'h00;
    logic sie_setup = 1'b0;
    logic sie_sof = 1'b0;
    logic [10:0] sie_frame = 11'h000;
    logic [6:0] full_q;
    logic [5:0] stall_q, pid_reset_q, pr_seen;
    logic [1:0] lock_q;
    logic resume_q;
    logic [7:0] p [0:7];
    int err_count = 0;
    int samples_checked = 0;
    int res_cnt = 0;
    always #25 core_clk = ~core_clk;
    ueb_micro_model m (.core_clk(core_clk), .cmd_wr(cmd_wr),
        .data_wr(data_wr), .data_rd(data_rd), .din(din), .dout_q(dout_q),
        .dma_wr(dma_wr), .dma_din(dma_din), .transfer_end_n(transfer_end_n));
    // Short resume count keeps the run brief
    ueb_cmd_decoder #(.RESUME_CYC(20)) uut (.core_clk(core_clk),
        .rst_b(rst_b), .cmd_wr(cmd_wr), .data_wr(data_wr),
        .data_rd(data_rd), .din(din), .dout_q(dout_q), .dma_wr(dma_wr),
        .dma_din(dma_din), .transfer_end_n(transfer_end_n),
        .sie_rx_done(sie_rx_done), .sie_tx_done(sie_tx_done),
        .sie_setup(sie_setup), .sie_sof(sie_sof), .sie_frame(sie_frame),
        .full_q(full_q), .stall_q(stall_q), .pid_reset_q(pid_reset_q),
        .lock_q(lock_q), .resume_q(resume_q));
    always @(posedge core_clk)
    begin
        if (resume_q === 1'b1)
            res_cnt++;
    end
    // Latched as soon as the pulse appears, so a check one edge later sees it
    always @(pid_reset_q)
    begin
        if (rst_b)
            pr_seen = pr_seen | pid_reset_q;
    end
    function automatic logic [7:0] frame_byte(logic [10:0] f, bit hi);
        return hi ? {5'h00, f[10:8]} : f[7:0];
    endfunction
    task automatic cmd(input logic [7:0] c);
        m.strobe(1'b1, c);
    endtask
    task automatic give_verdict();
        $display("Checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(90755));
        pr_seen = 6'h00;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        `CHK("full", 7'h00, full_q)
        `CHK("stall", 6'h00, stall_q)
        `CHK("lock", 2'h0, lock_q)
        $display("test reset done");
        len = 8'(1 + $urandom % 8);
        for (int i = 0; i < 8; i++)
            p[i] = 8'($urandom);
        m.load(3'h3, len, p);
        // Diagnostic read-back; the device does not guard direction
        cmd(8'h03);
        cmd(ueb_pkg::CMD_BUFFER);
        m.rd(v);
        `CHK("byte0", 8'h00, v)
        m.rd(v);
        `CHK("len", len, v)
        for (int i = 0; i < len; i++)
        begin
            m.rd(v);
            `CHK("payload", p[i], v)
        end
        cmd(ueb_pkg::CMD_VALIDATE);
        `CHK("full3 set", 1'b1, full_q[3])
        $display("test buffer done");
        @(negedge core_clk) sie_rx_done = 7'h10;
        @(negedge core_clk) sie_rx_done = 7'h00;
        `CHK("full4 rx", 1'b1, full_q[4])
        cmd(8'h04);
        cmd(ueb_pkg::CMD_CLEAR); // Freed only once full was seen
        `CHK("full4 clr", 1'b0, full_q[4])
        $display("test clear done");
        for (int x = 0; x < 6; x++)
        begin
            cmd(ueb_pkg::CMD_STALL_FIRST + 8'(x));
            m.strobe(1'b0, 8'h01);
            `CHK("stall on", 1'b1, stall_q[x])
            pr_seen = 6'h00;
            cmd(ueb_pkg::CMD_STALL_FIRST + 8'(x));
            m.strobe(1'b0, 8'h00);
            `CHK("stall off", 1'b0, stall_q[x])
            `CHK("reinit", 1'b1, pr_seen[x])
        end
        `CHK("flushed", 1'b0, full_q[3])
        pr_seen = 6'h00;
        cmd(8'h42);
        m.strobe(1'b0, 8'h00);
        `CHK("reinit idle", 1'b1, pr_seen[2])
        $display("test stall done");
        cmd(8'h40);
        m.strobe(1'b0, 8'h01);
        cmd(8'h01);
        cmd(ueb_pkg::CMD_VALIDATE);
        pr_seen = 6'h00;
        @(negedge core_clk) sie_setup = 1'b1;
        @(negedge core_clk) sie_setup = 1'b0;
        `CHK("lock set", 2'h3, lock_q)
        `CHK("unstall", 1'b0, stall_q[0])
        `CHK("reinit su", 1'b1, pr_seen[0])
        `CHK("in flush", 1'b0, full_q[1])
        cmd(8'h00);
        cmd(ueb_pkg::CMD_VALIDATE);
        `CHK("locked", 1'b0, full_q[0])
        cmd(ueb_pkg::CMD_ACK_SETUP);
        `CHK("ack ep0", 2'h2, lock_q)
        cmd(8'h01);
        cmd(ueb_pkg::CMD_ACK_SETUP);
        `CHK("ack ep1", 2'h0, lock_q)
        cmd(8'h00);
        cmd(ueb_pkg::CMD_VALIDATE);
        `CHK("unlocked", 1'b1, full_q[0])
        $display("test setup done");
        @(negedge core_clk) sie_frame = 11'($urandom);
        sie_sof = 1'b1;
        @(negedge core_clk) sie_sof = 1'b0;
        cmd(ueb_pkg::CMD_FRAME);
        m.rd(v);
        `CHK("frame lo", frame_byte(sie_frame, 1'b0), v)
        m.rd(v);
        `CHK("frame hi", frame_byte(sie_frame, 1'b1), v)
        $display("test frame done");
        res_cnt = 0;
        cmd(ueb_pkg::CMD_RESUME);
        repeat (40) @(negedge core_clk);
        `CHK("resume", 20, res_cnt)
        $display("test resume done");
        f0 = 8'($urandom);
        m.dma_burst(127, f0);
        `CHK("not full", 1'b0, full_q[5])
        m.dma_burst(1, f0 + 8'd127);
        `CHK("bank full", 1'b1, full_q[5])
        m.dma_burst(3, f0);
        `CHK("bank2 open", 1'b0, full_q[6])
        m.eot();
        for (int i = 0; i < 10 && full_q[6] !== 1'b1; i++)
            @(negedge core_clk);
        `CHK("eot send", 1'b1, full_q[6])
        cmd(8'h05);
        cmd(ueb_pkg::CMD_BUFFER);
        m.rd(v);
        m.rd(v);
        `CHK("dma len", 8'd128, v)
        m.rd(v);
        `CHK("dma first", f0, v)
        $display("test dma done");
        give_verdict();
    end
    initial
    begin
        #5ms;
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
